// *** rtl/led_fault_pkg.sv ***
// Purpose: Shared constants and carriers for the LED driver fault manager
// Assumes: 200 MHz internal clock, comparator inputs from the analog front end
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite slave
package led_fault_pkg;

  localparam int unsigned NUM_CH          = 6;
  localparam int unsigned CLK_MHZ         = 200;

  // Times in their own units and derived cycle counts
  localparam int unsigned ENABLE_LOW_US   = 30;
  localparam int unsigned ENABLE_LOW_CYC  = ENABLE_LOW_US * CLK_MHZ;       // shortest time, exact product, no rounding
  localparam int unsigned SOFTSTART_MS    = 8;
  localparam int unsigned SS_STEPS        = 8;                             // first level plus seven more
  localparam int unsigned SS_STEP_CYC     = (SOFTSTART_MS * 1000 * CLK_MHZ + SS_STEPS - 1) / SS_STEPS;
  localparam int unsigned OPEN_DIM_CYCLES = 6;                             // dimming cycles at normal temp
  localparam int unsigned HOT_OPEN_US     = 800;
  localparam int unsigned HOT_OPEN_CYC    = HOT_OPEN_US * CLK_MHZ;

  // Current limit levels in mA
  localparam logic [11:0] ILIM_STEP_MA    = 12'h113;                       // 275 mA
  localparam logic [11:0] ILIM_FINAL_MA   = 12'h898;                       // 2200 mA

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam logic [7:0]  CHAN_OFS        = 8'h08;
  localparam logic [7:0]  ILIM_OFS        = 8'h0c;

  // Control register fields
  localparam int unsigned CTRL_STRETCH_LSB = 0;                            // soft-start stretch, 4 bits
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // Start-up states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_PRESTART= 3'h1,
    ST_INRUSH  = 3'h3,
    ST_SOFT    = 3'h2,
    ST_RUN     = 3'h6,
    ST_HOT     = 3'h7,
    ST_TRIP    = 3'h5
  } phase_t;

  // Comparator inputs as one group
  typedef struct packed {
    logic [NUM_CH-1:0] short_detect;    // channel above about 7.5 V
    logic [NUM_CH-1:0] in_reg;          // channel current at target
    logic              sw_over;         // switch current over limit
    logic              ovp_hit;         // overvoltage_sense at limit
    logic              ovp_20;          // overvoltage_sense above 20 %
    logic              switch_node_ok;  // switch_node above 1.2 V
    logic              fet_on;          // disconnect FET fully enhanced
    logic              temp_low;        // lower temperature threshold
    logic              temp_high;       // upper temperature threshold
    logic              temp_cool;       // cooled enough to restart
    logic              in_overcur;      // input current beyond limits
    logic              stable;          // LED feedback says stable
    logic              dim;             // dimming PWM level
    logic              enable;          // enable pin
    logic              undervoltage_lockout;
  } sense_t;

  localparam int unsigned SENSE_W = $bits(sense_t);

endpackage

// *** rtl/led_fault_mgr.sv ***
// Purpose: Start-up sequencing and fault management for a six-channel LED boost driver
// Assumes: Asynchronous comparator inputs; AXI4-Lite for status and soft-start stretch
// Notes:   All outputs registered; fault flag is open-drain, active low
//
// Function
// - Switch only after disconnect FET fully on
// - Start current limit at 275 mA
// - Seven more 275 mA steps up to 2.2A
// - Ramp at least 8ms, stretched at low dimming
// - End on-time when switch current exceeds limit
// - Latch fault flag on any fault
// - Clear flag only by reset, re-enable or undervoltage
// - Faulty channel off, others keep running
// - No open or short decisions while unstable; open time-out still disables
// - Input overcurrent switches all channels off
// - Disable channel above short threshold
// - Mark channel good at target current
// - Good channel falling below target is open
// - OVERVOLTAGE_SENSE or lower temp: non-good channels open
// - Open channel disabled after time-out
// - Shorter open time-out when hot
// - Raised forward voltage stays on unless OVERVOLTAGE_SENSE or lower temp
// - Undervoltage stops switching, resets all state except the stretch setting
// - Stay pre-start until switch node above 1.2V
// - OVERVOLTAGE_SENSE node rise then fall opens FET
// - Shut down after enable low 30us
// - Normal open time-out is six dimming cycles
// - Upper temp stops outputs; restart 75/50/25%
`timescale 1ns/1ps
module led_fault_mgr (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // Comparator inputs from the analog front end
  input  wire led_fault_pkg::sense_t        sense,
  // Power stage controls
  output logic                              gate_on,
  output logic                              disconnect_on,
  output logic [led_fault_pkg::NUM_CH-1:0]  ch_enable,
  output logic [11:0]                       ilim_ma,
  output logic [1:0]                        derate,
  // Open-drain fault flag
  output logic                              fault_o,
  output logic                              fault_oe,
  // AXI4-Lite slave
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);

  localparam int unsigned N = led_fault_pkg::NUM_CH;

  typedef struct packed {
    logic [2:0][led_fault_pkg::SENSE_W-1:0] sync;     // three-stage synchroniser
    led_fault_pkg::phase_t                  phase;
    logic [23:0]                            tmr;      // soft-start step / enable-low timer
    logic [2:0]                             step;
    logic [11:0]                            ilim;
    logic                                   gate;
    logic                                   fet;
    logic                                   ovp20_seen;
    logic [N-1:0]                           good;
    logic [N-1:0]                           open;
    logic [N-1:0]                           dis;
    logic [N-1:0][17:0]                     otmr;     // per-channel open time-out
    logic                                   dim_d;
    logic                                   flag;
    logic [1:0]                             derate;
    logic [3:0]                             stretch;
    logic                                   aw_got;
    logic                                   w_got;
    logic [7:0]                             awaddr;
    logic [31:0]                            wdata;
    logic [3:0]                             wstrb;
    logic                                   bvalid;
    logic [1:0]                             bresp;
    logic                                   rvalid;
    logic [31:0]                            rdata;
    logic [1:0]                             rresp;
    logic                                   en_seen;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  led_fault_pkg::sense_t s;   // synchronised comparator view, always the third stage
  logic                  dim_rise;
  logic [N-1:0]          to_open;

  // Soft-start limit for a step index
  function automatic logic [11:0] step_limit(input logic [2:0] idx);
    step_limit = 12'(led_fault_pkg::ILIM_STEP_MA * (12'(idx) + 12'h001));
  endfunction

  // Only the second and third stages feed logic; first stage stays unread
  always_comb begin
    s = led_fault_pkg::sense_t'(st_r.sync[2]);
    if (st_r.sync[1] == st_r.sync[2]) begin
      s = led_fault_pkg::sense_t'(st_r.sync[1]);
    end
  end

  assign dim_rise = s.dim & ~st_r.dim_d;

  // Next-state logic for the whole block
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sync[0] = sense;
    st_nxt.sync[1] = st_r.sync[0];
    st_nxt.sync[2] = st_r.sync[1];
    st_nxt.dim_d   = s.dim;
    to_open        = '0;

    // Start-up sequence
    case (st_r.phase)
      led_fault_pkg::ST_OFF: begin
        st_nxt.gate = 1'b0;
        st_nxt.fet  = 1'b0;
        st_nxt.tmr  = '0;
        if (s.enable) begin
          st_nxt.phase = led_fault_pkg::ST_PRESTART;
        end
      end
      led_fault_pkg::ST_PRESTART: begin
        if (s.switch_node_ok) begin
          st_nxt.fet   = 1'b1;
          st_nxt.phase = led_fault_pkg::ST_INRUSH;
        end
      end
      led_fault_pkg::ST_INRUSH: begin
        if (s.fet_on) begin
          st_nxt.phase = led_fault_pkg::ST_SOFT;
          st_nxt.step  = 3'h0;
          st_nxt.ilim  = step_limit(3'h0);
          st_nxt.tmr   = '0;
        end
      end
      led_fault_pkg::ST_SOFT: begin
        // With stretch set, the timer only counts while dimming is high, so short duty ramps slower
        if (!s.dim && st_r.stretch != 4'h0) begin
          st_nxt.tmr = st_r.tmr;
        end else begin
          st_nxt.tmr = st_r.tmr + 24'h000001;
        end
        if (st_r.tmr >= 24'(led_fault_pkg::SS_STEP_CYC - 1)) begin
          st_nxt.tmr = '0;
          if (st_r.step == 3'h7) begin
            st_nxt.phase = led_fault_pkg::ST_RUN;
            st_nxt.ilim  = led_fault_pkg::ILIM_FINAL_MA;
          end else begin
            st_nxt.step = st_r.step + 3'h1;
            st_nxt.ilim = step_limit(st_r.step + 3'h1);
          end
        end
      end
      led_fault_pkg::ST_RUN: begin
      end
      led_fault_pkg::ST_HOT: begin
        if (s.temp_cool) begin
          st_nxt.phase = led_fault_pkg::ST_RUN;
        end
      end
      led_fault_pkg::ST_TRIP: begin
        st_nxt.fet = 1'b0;                             // stays off until re-enable
      end
      default: begin
        st_nxt.phase = led_fault_pkg::ST_OFF;
      end
    endcase

    // Upper temperature stops switching during the ramp as well as in run
    if (s.temp_high && (st_r.phase == led_fault_pkg::ST_SOFT || st_r.phase == led_fault_pkg::ST_RUN)) begin
      st_nxt.phase = led_fault_pkg::ST_HOT;
      st_nxt.flag  = 1'b1;
      if (st_r.derate != 2'h3) begin
        st_nxt.derate = st_r.derate + 2'h1;
      end
    end

    // Cycle-by-cycle limit: gate follows limit comparator
    st_nxt.gate = (st_nxt.phase == led_fault_pkg::ST_SOFT || st_nxt.phase == led_fault_pkg::ST_RUN)
                  && !s.sw_over;

    // Overvoltage node rose above 20 % then fell: open the input FET
    if (s.ovp_20) begin
      st_nxt.ovp20_seen = 1'b1;
    end else if (st_r.ovp20_seen && st_r.phase != led_fault_pkg::ST_OFF) begin
      st_nxt.phase = led_fault_pkg::ST_TRIP;
      st_nxt.fet   = 1'b0;
      st_nxt.gate  = 1'b0;
      st_nxt.flag  = 1'b1;
    end

    // Input overcurrent kills every channel
    if (s.in_overcur && st_r.phase != led_fault_pkg::ST_OFF) begin
      st_nxt.phase = led_fault_pkg::ST_TRIP;
      st_nxt.gate  = 1'b0;
      st_nxt.flag  = 1'b1;
    end

    // Per-channel classification; open and short decisions held off while unstable, good marking and time-out are not
    for (int i = 0; i < N; i++) begin
      if (s.in_reg[i]) begin
        st_nxt.good[i] = 1'b1;
      end
      if (s.stable && st_r.phase == led_fault_pkg::ST_RUN && !st_r.dis[i]) begin
        if (st_r.good[i] && !s.in_reg[i]) begin
          to_open[i] = 1'b1;
        end
        // Raised forward voltage alone does not open a channel
        if ((s.ovp_hit || s.temp_low) && !st_r.good[i]) begin
          to_open[i] = 1'b1;
        end
        if (s.short_detect[i]) begin
          st_nxt.dis[i] = 1'b1;
          st_nxt.flag   = 1'b1;
        end
      end
      if (to_open[i] && !st_r.open[i]) begin
        st_nxt.open[i] = 1'b1;
        st_nxt.otmr[i] = '0;
      end
      // Time-out: dimming edges normally, clock cycles when hot
      if (st_r.open[i] && !st_r.dis[i]) begin
        if (s.temp_low) begin
          st_nxt.otmr[i] = st_r.otmr[i] + 18'h00001;
          if (st_r.otmr[i] >= 18'(led_fault_pkg::HOT_OPEN_CYC - 1)) begin
            st_nxt.dis[i] = 1'b1;
            st_nxt.flag   = 1'b1;
          end
        end else if (dim_rise) begin
          st_nxt.otmr[i] = st_r.otmr[i] + 18'h00001;
          if (st_r.otmr[i] >= 18'(led_fault_pkg::OPEN_DIM_CYCLES - 1)) begin
            st_nxt.dis[i] = 1'b1;
            st_nxt.flag   = 1'b1;
          end
        end
      end
    end

    // Enable low for 30 us shuts the device down and clears the flag
    if (!s.enable && st_r.phase != led_fault_pkg::ST_OFF) begin
      // Start from zero: the timer may still hold a ramp count
      st_nxt.tmr = st_r.en_seen ? st_r.tmr + 24'h000001 : 24'h000000;
      st_nxt.en_seen = 1'b1;
      if (st_r.en_seen && st_r.tmr >= 24'(led_fault_pkg::ENABLE_LOW_CYC)) begin
        st_nxt = '0;
        st_nxt.sync    = {st_r.sync[1], st_r.sync[0], sense};
        st_nxt.stretch = st_r.stretch;
        st_nxt.flag    = 1'b0;
      end
    end else if (st_r.en_seen) begin
      st_nxt.en_seen = 1'b0;
      st_nxt.tmr     = '0;
    end

    // Register bus: write address and data in either order
    if (s_axi_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bresp  = led_fault_pkg::RESP_OKAY;
      if (st_r.awaddr == led_fault_pkg::CTRL_OFS) begin
        if (st_r.wstrb[0]) begin
          st_nxt.stretch = st_r.wdata[led_fault_pkg::CTRL_STRETCH_LSB +: 4];
        end
      end else if (st_r.awaddr != led_fault_pkg::STATUS_OFS && st_r.awaddr != led_fault_pkg::CHAN_OFS
                   && st_r.awaddr != led_fault_pkg::ILIM_OFS) begin
        st_nxt.bresp = led_fault_pkg::RESP_DECERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = led_fault_pkg::RESP_OKAY;
      case (s_axi_araddr)
        led_fault_pkg::CTRL_OFS:   st_nxt.rdata = {28'h0000000, st_r.stretch};
        led_fault_pkg::STATUS_OFS: st_nxt.rdata = {23'h000000, st_r.derate, st_r.step,
                                                   st_r.phase, st_r.flag};
        led_fault_pkg::CHAN_OFS:   st_nxt.rdata = {8'h00, 2'h0, st_r.dis, 2'h0, st_r.open, 2'h0, st_r.good};
        led_fault_pkg::ILIM_OFS:   st_nxt.rdata = {20'h00000, st_r.ilim};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = led_fault_pkg::RESP_DECERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // State register; undervoltage clears all state except the stretch setting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (s.undervoltage_lockout) begin
      st_r         <= '0;
      st_r.sync[0] <= sense;
      st_r.sync[1] <= st_r.sync[0];
      st_r.sync[2] <= st_r.sync[1];
      st_r.stretch <= st_r.stretch;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_on       <= 1'b0;
      disconnect_on <= 1'b0;
      ch_enable     <= '0;
      ilim_ma       <= '0;
      derate        <= 2'h0;
      fault_o       <= 1'b0;
      fault_oe      <= 1'b0;
    end else begin
      gate_on       <= st_nxt.gate;
      disconnect_on <= st_nxt.fet;
      ch_enable     <= (st_nxt.phase == led_fault_pkg::ST_SOFT || st_nxt.phase == led_fault_pkg::ST_RUN)
                       ? ~st_nxt.dis : '0;
      ilim_ma       <= st_nxt.ilim;
      derate        <= st_nxt.derate;
      fault_o       <= 1'b0;
      fault_oe      <= st_nxt.flag;
    end
  end

  // Bus handshakes
  assign s_axi_awready = !st_r.aw_got;
  assign s_axi_wready  = !st_r.w_got;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

endmodule

// *** test/analog_front_model.sv ***
// Purpose: Analog front end model facing the fault manager
// Assumes: Bench sets raw comparator levels in drive
// Notes:   FET and channels follow only the block's commands
`timescale 1ns/1ps
module analog_front_model (
  // Clock
  input  wire logic                              aclk,
  // Power stage commands from the block
  input  wire logic                              disconnect_on,
  input  wire logic [led_fault_pkg::NUM_CH-1:0]  ch_enable,
  // Bench levels in, comparator levels out
  input  wire led_fault_pkg::sense_t             drive,
  output led_fault_pkg::sense_t                  sense
);
  logic [3:0] fet_sr;

  // Gate charge: full enhancement lags the command by four cycles
  always_ff @(posedge aclk) begin
    fet_sr <= {fet_sr[2:0], disconnect_on};
  end

  // A switched-off FET or channel never reports success
  always_comb begin
    sense        = drive;
    sense.fet_on = drive.fet_on & fet_sr[3];
    sense.in_reg = drive.in_reg & ch_enable;
  end
endmodule

// *** test/led_fault_mgr_asserts.sv ***
// Purpose: Port-level checks of the fault manager
// Assumes: Sense fields are raw, synchronised inside
// Notes:   Six-cycle holds cover sync and output flops
`timescale 1ns/1ps
module led_fault_mgr_check (
  // Clock and reset
  input wire logic                              aclk,
  input wire logic                              aresetn,
  // Watched ports
  input wire led_fault_pkg::sense_t             sense,
  input wire logic                              gate_on,
  input wire logic                              disconnect_on,
  input wire logic [led_fault_pkg::NUM_CH-1:0]  ch_enable,
  input wire logic [11:0]                       ilim_ma,
  input wire logic [1:0]                        derate,
  input wire logic                              fault_o,
  input wire logic                              fault_oe,
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic                              s_axi_rvalid
);
  logic [15:0] low_run;
  logic        was_off;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Enable-low run length; was_off marks a legal clearing event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_run <= 16'h0;
      was_off <= 1'b0;
    end else begin
      low_run <= sense.enable ? 16'h0 : low_run + {15'h0, low_run != 16'hffff};
      if (low_run >= 16'h1766 || sense.undervoltage_lockout) was_off <= 1'b1;
      else if ($rose(fault_oe)) was_off <= 1'b0;
    end
  end

  a_fet_before_gate: assert property ($rose(gate_on) |-> disconnect_on && $past(sense.fet_on, 2))
    else $error("gate before FET on");
  a_limit_legal: assert property (gate_on |-> ilim_ma != 12'h0 && ilim_ma <= 12'h898 && ilim_ma % 12'h113 == 12'h0)
    else $error("limit off grid");
  a_limit_step: assert property ($changed(ilim_ma) && $past(ilim_ma) != 12'h0 && ilim_ma > $past(ilim_ma) |-> ilim_ma == $past(ilim_ma) + 12'h113)
    else $error("limit step wrong");
  a_switch_cut: assert property (sense.sw_over [*6] |=> !gate_on)
    else $error("gate kept at limit");
  a_flag_latch: assert property ($fell(fault_oe) |-> was_off)
    else $error("flag cleared early");
  a_hot_flag: assert property (gate_on ##1 (sense.temp_high && !sense.undervoltage_lockout) [*6] |=> fault_oe)
    else $error("no flag when hot");
  a_hot_stop: assert property (gate_on ##1 (sense.temp_high && !sense.undervoltage_lockout) [*6] |=> !gate_on && ch_enable == '0)
    else $error("outputs on when hot");
  a_overcur_off: assert property (sense.in_overcur [*6] |=> !gate_on && !disconnect_on && ch_enable == '0)
    else $error("outputs on at overcurrent");
  a_lockout_clear: assert property (sense.undervoltage_lockout [*6] |=> !gate_on && !disconnect_on && !fault_oe && derate == 2'h0)
    else $error("state kept through lockout");
  a_enable_off: assert property (low_run >= 16'h177a |-> !gate_on && !disconnect_on)
    else $error("no shutdown");
  a_derate_step: assert property ($changed(derate) && derate != 2'h0 |-> derate == $past(derate) + 2'h1)
    else $error("derate skipped a step");
  a_flag_pin: assert property (fault_oe |-> !fault_o)
    else $error("flag pin not pulled low");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind led_fault_mgr led_fault_mgr_check led_fault_mgr_check_inst (.aclk, .aresetn, .sense, .gate_on, .disconnect_on,
  .ch_enable, .ilim_ma, .derate, .fault_o, .fault_oe, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// *** test/test_led_fault_mgr.sv ***
// Purpose: Self-checking bench for the LED driver fault manager
// Assumes: Fixed counts: enable filter 6000 cycles, soft-start step 200000
// Notes:   Soft-start never passes its first level
`timescale 1ns/1ps
module test_led_fault_mgr;
  logic                  aclk, aresetn, gate_on, disconnect_on, fault_o, fault_oe;
  led_fault_pkg::sense_t drv, sense;
  logic [5:0]            ch_enable;
  logic [11:0]           ilim_ma;
  logic [1:0]            derate, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]            s_axi_wstrb;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int                    n_fail, check_count;

  led_fault_mgr led_fault_mgr_inst (.aclk, .aresetn, .sense, .gate_on, .disconnect_on, .ch_enable, .ilim_ma,
    .derate, .fault_o, .fault_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  analog_front_model analog_front_model_inst (.aclk, .disconnect_on, .ch_enable, .drive(drv), .sense);

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ends at a falling edge, outputs settled
  task cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task wait_gate(input logic v);
    int n;
    n = 0;
    @(negedge aclk);
    while (gate_on !== v && n < 400) begin
      @(negedge aclk);
      n++;
    end
    chk("gate_on", v, gate_on);
  endtask

  // One AXI4-Lite write or read; channels released when taken
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    logic aw, w, ar, done;
    int   n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_bready  <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready  <= !wr;
    do begin
      @(negedge aclk);
      aw   = s_axi_awvalid && s_axi_awready;
      w    = s_axi_wvalid && s_axi_wready;
      ar   = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      r    = wr ? s_axi_bresp : s_axi_rresp;
      q    = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (done) {s_axi_bready, s_axi_rready} <= 2'b00;
      n++;
    end while (!done && n < 50);
    if (!done) chk("axi answer", 1, 0);
  endtask

  // Stretch, read-only limit, unmapped place
  task t_regs;
    chk("idle outputs", 0, {gate_on, disconnect_on, fault_o, fault_oe, derate, ch_enable, ilim_ma});
    axi(1'b1, led_fault_pkg::CTRL_OFS, 32'h5, rd, rsp);
    axi(1'b0, led_fault_pkg::CTRL_OFS, 32'h0, rd, rsp);
    chk("ctrl", 32'h5, rd);
    axi(1'b1, 8'h10, 32'h1, rd, rsp);
    chk("bad bresp", led_fault_pkg::RESP_DECERR, rsp);
    axi(1'b0, 8'h10, 32'h0, rd, rsp);
    chk("bad read", {30'h0, led_fault_pkg::RESP_DECERR}, {rd[29:0], rsp});
    axi(1'b1, led_fault_pkg::ILIM_OFS, 32'h7ff, rd, rsp);
    axi(1'b0, led_fault_pkg::ILIM_OFS, 32'h0, rd, rsp);
    chk("ilim kept", 32'h0, rd);
    axi(1'b1, led_fault_pkg::CTRL_OFS, 32'h0, rd, rsp);
  endtask

  // Start-up gating, first limit, cycle-by-cycle cut
  task t_start;
    @(posedge aclk) drv.enable <= 1'b1;
    cyc(60);
    chk("gate before node", 0, gate_on);
    @(posedge aclk) drv.switch_node_ok <= 1'b1;
    cyc(60);
    chk("gate before fet", 0, gate_on);
    @(posedge aclk) drv.fet_on <= 1'b1;
    wait_gate(1'b1);
    chk("first limit", 12'h113, ilim_ma);
    axi(1'b0, led_fault_pkg::ILIM_OFS, 32'h0, rd, rsp);
    chk("ilim reg", 32'h113, rd);
    @(posedge aclk) drv.sw_over <= 1'b1;
    cyc(8);
    chk("gate at limit", 0, gate_on);
    @(posedge aclk) drv.sw_over <= 1'b0;
    wait_gate(1'b1);
  endtask

  // Three hot events: flag, stop, derate 75/50/25
  task t_hot;
    for (int k = 1; k < 4; k++) begin
      @(posedge aclk) {drv.temp_high, drv.temp_low, drv.temp_cool} <= 3'b110;
      cyc(10);
      chk("hot stop", 0, {gate_on, ch_enable});
      chk("hot flag", 1, fault_oe);
      @(posedge aclk) {drv.temp_high, drv.temp_low, drv.temp_cool} <= 3'b001;
      wait_gate(1'b1);
      chk("derate", k, derate);
    end
    chk("flag kept", 1, fault_oe);
  endtask

  // Long disable, then a fresh start
  task cycle_enable;
    @(posedge aclk) drv.enable <= 1'b0;
    cyc(6100);
    chk("shut down", 0, {gate_on, disconnect_on, ch_enable});
    @(posedge aclk) drv.enable <= 1'b1;
    wait_gate(1'b1);
    chk("flag cleared", 0, fault_oe);
  endtask

  // Short enable glitch keeps state, long one clears
  task t_enable;
    @(posedge aclk) drv.enable <= 1'b0;
    cyc(1000);
    @(posedge aclk) drv.enable <= 1'b1;
    cyc(10);
    chk("short low", 2'b11, {disconnect_on, fault_oe});
    cycle_enable;
  endtask

  // Input overcurrent, then collapse of the output node
  task t_trips;
    @(posedge aclk) drv.in_overcur <= 1'b1;
    cyc(10);
    chk("overcurrent", 0, {gate_on, disconnect_on, ch_enable});
    @(posedge aclk) drv.in_overcur <= 1'b0;
    cyc(50);
    chk("trip held", 0, gate_on);
    cycle_enable;
    @(posedge aclk) drv.ovp_20 <= 1'b1;
    cyc(20);
    chk("node risen", 1, disconnect_on);
    @(posedge aclk) drv.ovp_20 <= 1'b0;
    cyc(10);
    chk("node fell", 0, disconnect_on);
    cycle_enable;
  endtask

  // Lockout clears all; restart after release
  task t_lockout;
    @(posedge aclk) {drv.temp_high, drv.temp_low, drv.temp_cool} <= 3'b110;
    cyc(10);
    @(posedge aclk) {drv.temp_high, drv.temp_low, drv.temp_cool, drv.undervoltage_lockout} <= 4'b0011;
    cyc(50);
    chk("lockout", 0, {gate_on, disconnect_on, fault_oe, derate, ch_enable});
    @(posedge aclk) drv.undervoltage_lockout <= 1'b0;
    wait_gate(1'b1);
    chk("limit after lockout", 12'h113, ilim_ma);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog: the sequence needs about 20000 cycles
  initial begin
    #300000;
    n_fail++;
    $display("mismatch watchdog expected finish seen hang");
    stop_test;
  end

  // Main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    aresetn = 1'b0;
    drv = '0;
    drv.temp_cool = 1'b1;
    drv.stable = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    t_regs;
    t_start;
    t_hot;
    t_enable;
    t_trips;
    t_lockout;
    stop_test;
  end
endmodule
